// [verilog/alu_pkg.sv]
`default_nettype none
// ==========================================================
// shared constants for the arithmetic core
// ==========================================================
package alu_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;

    // register byte offsets on the register bus
    localparam logic [7:0] OFS_OPERAND_A = 8'h00;
    localparam logic [7:0] OFS_OPERAND_B = 8'h04;
    localparam logic [7:0] OFS_SYS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_COMMAND   = 8'h0c;
    localparam logic [7:0] OFS_RESULT    = 8'h10;

    // system_condition_flags bit positions
    localparam int FLG_Z = 0;
    localparam int FLG_C = 1;
    localparam int FLG_V = 2;
    localparam int FLG_N = 3;
    localparam int FLG_D = 4;
    localparam int FLG_U = 5;

    // reset values
    localparam logic [7:0]  SYS_FLAGS_RST = 8'h00;
    localparam logic [15:0] OPERAND_RST   = 16'h0000;

    // command register busy bit
    localparam int CMD_BUSY_BIT = 31;

    // decimal correction constants
    localparam logic [3:0] DEC_ADJ = 4'h6;
    localparam logic [4:0] DEC_MAX = 5'h09;

    // flag update masks, bit order N V C Z as in the flag register
    localparam logic [3:0] UPD_ALL  = 4'hf;
    localparam logic [3:0] UPD_NZ   = 4'h9;
    localparam logic [3:0] UPD_NONE = 4'h0;

    typedef enum logic [3:0] {
        OP_ADD   = 4'b0000,
        OP_ADC   = 4'b0001,
        OP_SUB   = 4'b0010,
        OP_SBC   = 4'b0011,
        OP_NEG   = 4'b0100,
        OP_INV   = 4'b0101,
        OP_SEXT  = 4'b0110,
        OP_ADD16 = 4'b1000,
        OP_ADC16 = 4'b1001,
        OP_SUB16 = 4'b1010,
        OP_SBC16 = 4'b1011
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } seq_state_t;

endpackage

`default_nettype wire

// [verilog/alu_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link between sequencer and arithmetic unit
// ==========================================================
interface alu_if;
    import alu_pkg::*;
    logic        start;
    op_t         op;
    logic [15:0] a;
    logic [15:0] b;
    logic [7:0]  flags;
    logic        done;
    logic [15:0] result;
    logic [3:0]  nvcz;
    logic [3:0]  upd;

    modport ctrl (output start, output op, output a, output b, output flags,
                  input done, input result, input nvcz, input upd);
    modport unit (input start, input op, input a, input b, input flags,
                  output done, output result, output nvcz, output upd);
endinterface

`default_nettype wire

// [verilog/alu_unit.sv]
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// arithmetic unit: one registered result per start pulse
// ==========================================================
module alu_unit (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    alu_if.unit       lnk
);
    import alu_pkg::*;

    // one bcd or binary digit: returns {carry_or_borrow, digit}
    function automatic logic [4:0] digit_op(input logic [3:0] x, input logic [3:0] y,
                                            input logic cin, input logic sub, input logic dec);
        logic [4:0] s;
        logic [3:0] r;
        logic       co;
        if (sub) begin
            s = {1'b0, x} - {1'b0, y} - {4'h0, cin};
        end else begin
            s = {1'b0, x} + {1'b0, y} + {4'h0, cin};
        end
        r  = s[3:0];
        co = s[4];
        // decimal carry at ten, borrow corrected by six
        if (dec && !sub && (s > DEC_MAX)) begin
            r  = s[3:0] + DEC_ADJ;
            co = 1'b1;
        end
        if (dec && sub && s[4]) begin
            r = s[3:0] - DEC_ADJ;
        end
        return {co, r};
    endfunction

    // binary add or subtract, 8 or 16 bit: returns {v, c, result}
    function automatic logic [17:0] bin_op(input logic [15:0] x, input logic [15:0] y,
                                           input logic cin, input logic sub, input logic wide);
        logic [16:0] s;
        logic        c;
        logic        mx;
        logic        my;
        logic        mr;
        logic        v;
        if (sub) begin
            s = {1'b0, x} - {1'b0, y} - {16'h0000, cin};
        end else begin
            s = {1'b0, x} + {1'b0, y} + {16'h0000, cin};
        end
        c  = wide ? s[16] : s[8];
        mx = wide ? x[15] : x[7];
        my = wide ? y[15] : y[7];
        mr = wide ? s[15] : s[7];
        v  = sub ? ((mx != my) && (mr != mx)) : ((mx == my) && (mr != mx));
        return {v, c, s[15:0]};
    endfunction

    logic        eligible;
    logic        dec;
    logic        unp;
    logic        cin;
    logic        sub;
    logic [15:0] x;
    logic [15:0] y;
    logic [4:0]  lo;
    logic [4:0]  hi;
    logic [17:0] bn;
    logic [7:0]  r8;
    logic [15:0] res_d;
    logic [3:0]  nvcz_d;
    logic [3:0]  upd_d;
    logic        done_q;
    logic [15:0] result_q;
    logic [3:0]  nvcz_q;
    logic [3:0]  upd_q;

    // ==========================================================
    // operand steering and mode selection
    // ==========================================================
    always_comb begin
        eligible = (lnk.op == OP_ADD) || (lnk.op == OP_ADC) || (lnk.op == OP_SUB)
                || (lnk.op == OP_SBC) || (lnk.op == OP_NEG);
        dec = eligible && lnk.flags[FLG_D];
        unp = eligible && lnk.flags[FLG_U];
        cin = ((lnk.op == OP_ADC) || (lnk.op == OP_SBC) || (lnk.op == OP_ADC16)
            || (lnk.op == OP_SBC16)) && lnk.flags[FLG_C];
        sub = (lnk.op == OP_SUB) || (lnk.op == OP_SBC) || (lnk.op == OP_NEG)
           || (lnk.op == OP_SUB16) || (lnk.op == OP_SBC16);
        // negate is zero minus the operand, so it shares the subtract path
        x = (lnk.op == OP_NEG) ? 16'h0000 : lnk.a;
        y = (lnk.op == OP_NEG) ? lnk.a : lnk.b;
        if (!lnk.op[3]) begin
            x = {8'h00, x[7:0]};
            y = {8'h00, y[7:0]};
        end
        lo = digit_op(x[3:0], y[3:0], cin, sub, dec);
        hi = digit_op(x[7:4], y[7:4], lo[4], sub, dec);
        bn = bin_op(x, y, cin, sub, lnk.op[3]);
    end

    // ==========================================================
    // result and flag formation
    // ==========================================================
    always_comb begin
        r8     = bn[7:0];
        res_d  = {lnk.a[15:8], bn[7:0]};
        nvcz_d = 4'h0;
        upd_d  = UPD_NONE;
        case (lnk.op)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_NEG: begin
                upd_d = UPD_ALL;
                if (unp) begin
                    // upper nibble of both operands ignored, result high nibble zero
                    r8 = {4'h0, lo[3:0]};
                    nvcz_d[FLG_N] = dec ? 1'b0 : lo[3];
                    nvcz_d[FLG_C] = lo[4];
                    nvcz_d[FLG_Z] = (lo[3:0] == 4'h0);
                    nvcz_d[FLG_V] = dec ? 1'b0 : (sub ? ((x[3] != y[3]) && (lo[3] != x[3]))
                                                      : ((x[3] == y[3]) && (lo[3] != x[3])));
                end else if (dec) begin
                    r8 = {hi[3:0], lo[3:0]};
                    nvcz_d[FLG_C] = hi[4];
                    nvcz_d[FLG_Z] = ({hi[3:0], lo[3:0]} == 8'h00);
                end else begin
                    nvcz_d[FLG_N] = bn[7];
                    nvcz_d[FLG_V] = bn[17];
                    nvcz_d[FLG_C] = bn[16];
                    nvcz_d[FLG_Z] = (bn[7:0] == 8'h00);
                end
                res_d = {lnk.a[15:8], r8};
            end
            OP_INV: begin
                // carry and overflow stay as they were
                res_d = {lnk.a[15:8], ~lnk.a[7:0]};
                nvcz_d[FLG_N] = ~lnk.a[7];
                nvcz_d[FLG_Z] = (lnk.a[7:0] == 8'hff);
                upd_d = UPD_NZ;
            end
            OP_SEXT: begin
                res_d = {{8{lnk.a[7]}}, lnk.a[7:0]};
            end
            OP_ADD16, OP_ADC16, OP_SUB16, OP_SBC16: begin
                res_d = bn[15:0];
                nvcz_d[FLG_N] = bn[15];
                nvcz_d[FLG_V] = bn[17];
                nvcz_d[FLG_C] = bn[16];
                nvcz_d[FLG_Z] = (bn[15:0] == 16'h0000);
                upd_d = UPD_ALL;
            end
            default: begin
                res_d = lnk.a;
            end
        endcase
    end

    // ==========================================================
    // output stage, captured on the start pulse
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q   <= 1'b0;
            result_q <= OPERAND_RST;
            nvcz_q   <= 4'h0;
            upd_q    <= UPD_NONE;
        end else if (ce) begin
            done_q <= lnk.start;
            if (lnk.start) begin
                result_q <= res_d;
                nvcz_q   <= nvcz_d;
                upd_q    <= upd_d;
            end
        end
    end

    assign lnk.done   = done_q;
    assign lnk.result = result_q;
    assign lnk.nvcz   = nvcz_q;
    assign lnk.upd    = upd_q;

endmodule

`default_nettype wire

// [verilog/alu_core.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - negatives are two's complement; negative flag copies result top bit.
// - invert gives 8-bit ones' complement; negate gives 8-bit two's complement.
// - sign extend copies low byte sign bit into all high byte bits.
// - carry set when unsigned result leaves 0-255 or 0-65535.
// - overflow set when signed result leaves -128..127 or -32768..32767.
// - carry and overflow both computed on every arithmetic operation; decimal mode here clears overflow instead.
// - decimal and unpack modes affect only 8-bit add, adc, sub, sbc, negate.
// - decimal mode bit is bit 4 of the flag register.
// - decimal mode gives a corrected two-digit bcd result.
// - decimal result clears negative and overflow; carry and zero from result.
// - unpack mode uses low nibbles only; result high nibble is zero.
// - unpack flags: negative is bit 3, carry from bit 3, zero on nibble.
// - unpack overflow set when signed nibble leaves -8..7.
// - decimal and unpack may be selected together or separately.
// - decimal bit one selects bcd arithmetic, zero selects hexadecimal.
// - unpack bit one selects nibble arithmetic, zero selects full 8 bits.
module alu_core (
    input  wire logic                       CLOCK,
    input  wire logic                       RST_N,
    input  wire logic                       CE,
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [alu_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [alu_pkg::DATA_W-1:0] PWDATA,
    output var  logic [alu_pkg::DATA_W-1:0] PRDATA,
    output var  logic                       PREADY,
    output var  logic                       PSLVERR
);
    import alu_pkg::*;

    alu_if      lnk ();
    seq_state_t state_q;
    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic [7:0]  flags_q;
    logic [15:0] result_q;
    op_t         cmd_op_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        setup;
    logic        access;
    logic        wr_ok;
    logic        busy;
    logic        bad_req;

    // true for a known operation code
    function automatic logic op_known(input logic [3:0] code);
        case (code)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_NEG, OP_INV, OP_SEXT,
            OP_ADD16, OP_ADC16, OP_SUB16, OP_SBC16: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // read data for a byte address; unmapped reads give zero
    function automatic logic [31:0] rd_mux(input logic [7:0] adr, input logic bsy);
        case (adr)
            OFS_OPERAND_A: return {16'h0000, opa_q};
            OFS_OPERAND_B: return {16'h0000, opb_q};
            OFS_SYS_FLAGS: return {24'h000000, flags_q};
            OFS_COMMAND:   return {bsy, 27'h0000000, cmd_op_q};
            OFS_RESULT:    return {16'h0000, result_q};
            default:       return 32'h00000000;
        endcase
    endfunction

    // ==========================================================
    // apb slave: every transfer answers in its first access cycle
    // ==========================================================
    assign busy   = (state_q != ST_IDLE);
    assign setup  = PSEL && !PENABLE && !pready_q;
    assign access = PSEL && PENABLE && pready_q;
    assign wr_ok  = access && PWRITE && !pslverr_q;

    // unmapped offsets, writes to the result, and refused commands error out
    always_comb begin
        bad_req = 1'b0;
        case (PADDR)
            OFS_OPERAND_A, OFS_OPERAND_B, OFS_SYS_FLAGS: bad_req = 1'b0;
            OFS_RESULT:  bad_req = PWRITE;
            OFS_COMMAND: bad_req = PWRITE && (busy || !op_known(PWDATA[3:0]));
            default:     bad_req = 1'b1;
        endcase
    end

    // answer is prepared in the setup cycle so it leaves a flip-flop
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else if (CE) begin
            pready_q  <= setup;
            pslverr_q <= setup && bad_req;
            if (setup && !PWRITE) begin
                prdata_q <= rd_mux(PADDR, busy);
            end
        end
    end

    // ==========================================================
    // operand registers
    // ==========================================================
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            opa_q <= OPERAND_RST;
            opb_q <= OPERAND_RST;
        end else if (CE) begin
            if (wr_ok && (PADDR == OFS_OPERAND_A)) begin
                opa_q <= PWDATA[15:0];
            end
            if (wr_ok && (PADDR == OFS_OPERAND_B)) begin
                opb_q <= PWDATA[15:0];
            end
        end
    end

    // ==========================================================
    // system condition flags: software writes, results update
    // ==========================================================
    // the arithmetic update wins over a software write landing in the same
    // cycle, so a finished result never loses its flags
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            flags_q <= SYS_FLAGS_RST;
        end else if (CE) begin
            if (wr_ok && (PADDR == OFS_SYS_FLAGS)) begin
                flags_q <= PWDATA[7:0];
            end
            if ((state_q == ST_WAIT) && lnk.done) begin
                for (int i = 0; i < 4; i++) begin
                    if (lnk.upd[i]) begin
                        flags_q[i] <= lnk.nvcz[i];
                    end
                end
            end
        end
    end

    // ==========================================================
    // command sequencer
    // ==========================================================
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_q  <= ST_IDLE;
            cmd_op_q <= OP_ADD;
        end else if (CE) begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_ok && (PADDR == OFS_COMMAND)) begin
                        cmd_op_q <= op_t'(PWDATA[3:0]);
                        state_q  <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (lnk.done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // result register, loaded when the unit reports done
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            result_q <= OPERAND_RST;
        end else if (CE) begin
            if ((state_q == ST_WAIT) && lnk.done) begin
                result_q <= lnk.result;
            end
        end
    end

    // operands are sampled by the unit on the start pulse only
    assign lnk.start = (state_q == ST_ISSUE);
    assign lnk.op    = cmd_op_q;
    assign lnk.a     = opa_q;
    assign lnk.b     = opb_q;
    assign lnk.flags = flags_q;

    alu_unit u_unit (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .ce    (CE),
        .lnk   (lnk.unit)
    );

    assign PRDATA  = prdata_q;
    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;

endmodule

`default_nettype wire

// [bench/alu_core_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// register bus checks on the core's top-level ports
// ==========================================================
module alu_core_chk (
    input wire logic                       CLOCK,
    input wire logic                       RST_N,
    input wire logic                       CE,
    input wire logic                       PSEL,
    input wire logic                       PENABLE,
    input wire logic                       PWRITE,
    input wire logic [alu_pkg::ADDR_W-1:0] PADDR,
    input wire logic [alu_pkg::DATA_W-1:0] PWDATA,
    input wire logic [alu_pkg::DATA_W-1:0] PRDATA,
    input wire logic                       PREADY,
    input wire logic                       PSLVERR
);
    import alu_pkg::*;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    logic [1:0] mode_q;
    logic       mapped;
    logic       rd_done;

    // mode bits only change by software writes, so a shadow predicts them
    always_ff @(posedge CLOCK) begin
        if (!RST_N)
            mode_q <= 2'h0;
        else if (CE && PREADY && PWRITE && PADDR == OFS_SYS_FLAGS)
            mode_q <= PWDATA[FLG_U:FLG_D];
    end

    // decode of the five mapped words and of a finished read
    assign mapped  = PADDR inside {OFS_OPERAND_A, OFS_OPERAND_B, OFS_SYS_FLAGS, OFS_COMMAND, OFS_RESULT};
    assign rd_done = PREADY && !PWRITE;

    // ==========================================================
    // assertions
    // ==========================================================
    setup_answer_a: assert property (PSEL && !PENABLE && CE |=> PREADY)
        else $error("no ready one cycle after setup");
    ready_pulse_a: assert property (PREADY && CE |=> !PREADY)
        else $error("ready held past one cycle");
    ready_cause_a: assert property ($rose(PREADY) |-> $past(PSEL) && !$past(PENABLE))
        else $error("ready without a setup cycle");
    unmapped_err_a: assert property (PREADY && !mapped |-> PSLVERR)
        else $error("unmapped access not refused");
    result_ro_a: assert property (PREADY && PWRITE && PADDR == OFS_RESULT |-> PSLVERR)
        else $error("result write not refused");
    mapped_read_a: assert property (rd_done && mapped |-> !PSLVERR)
        else $error("mapped read refused");
    err_zero_a: assert property (rd_done && PSLVERR |-> PRDATA == 32'h0)
        else $error("refused read returned data");
    mode_keep_a: assert property (
        rd_done && PADDR == OFS_SYS_FLAGS |-> PRDATA[FLG_U:FLG_D] == mode_q)
        else $error("mode bits differ from last write");
    result_width_a: assert property (rd_done && PADDR == OFS_RESULT |-> PRDATA[31:16] == 16'h0)
        else $error("result upper lanes not zero");

    cmd_write_c: cover property (PREADY && PWRITE && PADDR == OFS_COMMAND && !PSLVERR);
    refused_c: cover property (PREADY && PSLVERR);
    dec_read_c: cover property (rd_done && PADDR == OFS_SYS_FLAGS && PRDATA[FLG_D]);
endmodule

bind alu_core alu_core_chk chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR)
);

`default_nettype wire

// [bench/test_alu_core.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the arithmetic core
// ==========================================================
module test_alu_core;
    import alu_pkg::*;

    // row: mode {u,d}, op, a, b, carry in, result, flags nvcz
    typedef struct packed {
        logic [3:0]  m;
        logic [3:0]  op;
        logic [15:0] a;
        logic [15:0] b;
        logic [3:0]  c;
        logic [15:0] r;
        logic [3:0]  f;
    } row_t;

    logic        CLOCK   = 1'b0;
    logic        RST_N   = 1'b0;
    logic        CE      = 1'b1;
    logic        PSEL    = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE  = 1'b0;
    logic [7:0]  PADDR   = 8'h00;
    logic [31:0] PWDATA  = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        b2b     = 1'b0;
    logic [31:0] q;
    logic        e;
    int          fail_count = 0;
    int          n_checks   = 0;

    row_t rows [37] = '{
        64'h0_0_005a_00a5_0_00ff_8, 64'h0_0_125b_00a5_0_1200_3, 64'h0_0_005b_0025_0_0080_c,
        64'h0_2_005a_005a_0_0000_1, 64'h0_2_005a_005b_0_00ff_a, 64'h0_2_005a_00da_0_0080_e,
        64'h0_1_007f_0000_1_0080_c, 64'h0_3_0000_0000_1_00ff_a, 64'h0_4_007f_0000_0_0081_a,
        64'h0_4_0080_0000_0_0080_e, 64'h0_4_0000_0000_0_0000_1, 64'h1_0_0055_0028_0_0083_0,
        64'h1_0_0074_0098_0_0072_2, 64'h1_2_0055_0055_0_0000_1, 64'h1_2_0055_0028_0_0027_0,
        64'h1_2_0074_0098_0_0076_2, 64'h1_1_0099_0000_1_0000_3, 64'h1_3_0000_0000_1_0099_2,
        64'h1_4_0001_0000_0_0099_2, 64'h2_0_0020_00d0_0_0000_1, 64'h2_0_002e_0053_0_0001_2,
        64'h2_0_00c7_0052_0_0009_c, 64'h2_2_0005_0016_0_000f_a, 64'h2_4_0008_0000_0_0008_e,
        64'h2_3_0003_0000_1_0002_0, 64'h2_1_0007_0001_1_0009_c, 64'h3_0_0038_0095_0_0003_2,
        64'h3_2_0003_0005_0_0008_2, 64'h3_1_0004_0005_1_0000_3, 64'h3_4_0003_0000_0_0007_2,
        64'h3_5_000f_0000_1_00f0_a, 64'h1_6_0081_0000_1_ff81_2, 64'h3_8_7fff_0001_0_8000_c,
        64'h0_8_ffff_0001_0_0000_3, 64'h0_a_0000_0001_0_ffff_a, 64'h0_9_ffff_0000_1_0000_3,
        64'h0_b_8000_0000_1_7fff_4
    };

    alu_core uut (
        .CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR)
    );

    // 20 MHz clock
    always #25 CLOCK = ~CLOCK;

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string s);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, s, g, x);
        end
    endtask

    task automatic chk_e(input logic g, input logic x, input string s);
        chk({31'h0, g}, {31'h0, x}, s);
    endtask

    task automatic do_reset();
        RST_N <= 1'b0;
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
    endtask

    // one transfer entered after an edge; b2b keeps the bus for a setup next
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        // a slave that never answers is a mismatch, not a silent hang
        if (PREADY !== 1'b1) begin
            fail_count++;
            $display("BAD %0t no ready", $time);
        end
        q = PRDATA;
        e = PSLVERR;
        if (!b2b) begin
            PSEL    <= 1'b0;
            PENABLE <= 1'b0;
            @(posedge CLOCK);
        end
    endtask

    // poll the busy bit with a bounded count
    task automatic wait_idle();
        int n = 0;
        do begin
            xfer(1'b0, OFS_COMMAND, 32'h0);
            n++;
        end while (q[CMD_BUSY_BIT] !== 1'b0 && n < 8);
        // a command that never finishes must not slip through as idle
        if (q[CMD_BUSY_BIT] !== 1'b0) begin
            fail_count++;
            $display("BAD %0t busy stuck", $time);
        end
    endtask

    task automatic run(input row_t t);
        xfer(1'b1, OFS_SYS_FLAGS, {26'h0, t.m[1:0], 2'h0, t.c[0], 1'b0});
        xfer(1'b1, OFS_OPERAND_A, {16'h0, t.a});
        xfer(1'b1, OFS_OPERAND_B, {16'h0, t.b});
        xfer(1'b1, OFS_COMMAND, {28'h0, t.op});
        wait_idle();
        xfer(1'b0, OFS_RESULT, 32'h0);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog: the run needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge CLOCK);
        fail_count++;
        $display("BAD %0t watchdog", $time);
        give_verdict();
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        do_reset();
        foreach (rows[i]) begin
            run(rows[i]);
            chk(q, {16'h0, rows[i].r}, "result");
            xfer(1'b0, OFS_SYS_FLAGS, 32'h0);
            chk(q, {26'h0, rows[i].m[1:0], rows[i].f}, "flags");
        end
        $display("test table done");
        // reset in mid-run clears every register
        do_reset();
        for (int k = 0; k < 5; k++) begin
            xfer(1'b0, 8'(k * 4), 32'h0);
            chk(q, 32'h0, "reset value");
        end
        $display("test reset done");
        // refused accesses answer with an error and change nothing
        xfer(1'b1, OFS_RESULT, 32'h0000_1234);
        chk_e(e, 1'b1, "result write");
        xfer(1'b1, OFS_COMMAND, 32'h0000_0007);
        chk_e(e, 1'b1, "unknown op");
        xfer(1'b0, 8'h02, 32'h0);
        chk_e(e, 1'b1, "unaligned read");
        xfer(1'b0, 8'h14, 32'h0);
        chk(q, 32'h0, "unmapped data");
        xfer(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h0, "result kept");
        $display("test refusals done");
        // back-to-back command while busy is refused, the first one runs
        xfer(1'b1, OFS_OPERAND_A, 32'h0000_0001);
        xfer(1'b1, OFS_OPERAND_B, 32'h0000_0002);
        b2b = 1'b1;
        xfer(1'b1, OFS_COMMAND, {28'h0, OP_ADD});
        b2b = 1'b0;
        xfer(1'b1, OFS_COMMAND, {28'h0, OP_SUB});
        chk_e(e, 1'b1, "command while busy");
        wait_idle();
        chk(q, {28'h0, OP_ADD}, "command kept");
        xfer(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h0000_0003, "first command result");
        // busy is visible on a read right behind the command
        b2b = 1'b1;
        xfer(1'b1, OFS_COMMAND, {28'h0, OP_INV});
        b2b = 1'b0;
        xfer(1'b0, OFS_COMMAND, 32'h0);
        chk(q, 32'h8000_0005, "busy");
        wait_idle();
        $display("test busy done");
        // clock enable low in mid-operation must lose nothing
        xfer(1'b1, OFS_COMMAND, {28'h0, OP_NEG});
        CE <= 1'b0;
        repeat (4) @(posedge CLOCK);
        CE <= 1'b1;
        wait_idle();
        xfer(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h0000_00ff, "negate after stall");
        xfer(1'b0, OFS_SYS_FLAGS, 32'h0);
        chk(q, 32'h0000_000a, "flags after stall");
        // top flag bits are plain storage
        xfer(1'b1, OFS_SYS_FLAGS, 32'h0000_00ff);
        xfer(1'b0, OFS_SYS_FLAGS, 32'h0);
        chk(q, 32'h0000_00ff, "flag storage");
        $display("test stall done");
        give_verdict();
    end
endmodule

`default_nettype wire
